// ===== verilog/pic_ctrl.sv
// prioritised interrupt controller: latches, enables, priority, vectors, trap reset
`timescale 1ns/10ps
`default_nettype none
`include "pic_map.svh"
module pic_ctrl #(
   parameter int NSRC = 16,
   parameter int TRAP_LEN = `PIC_TRAP_RST_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire pic_pkg::pic_sfr_req_s sfr_req,
   output logic [7:0] sfr_rdata,
   input wire logic [15:0] src_req,
   input wire logic soft_irq,
   input wire logic illegal_opcode_irq,
   input wire logic fetch_trap_event,
   input wire logic wdog_event,
   input wire logic fetch_valid,
   input wire logic [15:0] fetch_addr,
   input wire logic ram_trap_select,
   input wire logic trap_reset_select,
   input wire logic wdog_reset_select,
   input wire logic ext_irq_zero_gate,
   input wire logic final_cycle,
   input wire logic return_op,
   input wire logic saved_mie,
   input wire logic [15:0] cur_pc,
   input wire logic [7:0] cur_psw,
   input wire logic [15:0] ram_base,
   input wire logic [15:0] ram_limit,
   output logic stack_we,
   output logic [7:0] stack_wdata,
   output pic_pkg::pic_accept_s accept,
   output logic busy,
   output logic trap_reset,
   output logic wdog_reset
);
   // ***************************************************
   // state
   // ***************************************************
   logic [15:0] latch_reg;
   logic [15:0] en_reg;
   pic_pkg::pic_state_e state_reg;
   logic [3:0] sel_reg;
   logic [15:0] vec_reg;
   logic sel_nm_reg;
   logic [15:0] pc_reg;
   logic [7:0] psw_reg;
   logic mie_reg;
   logic [15:0] wr_clr;
   logic [15:0] set_vec;
   logic [15:0] ack_clr;
   logic [15:0] eligible;
   logic any_nm;
   logic any_mask;
   logic [3:0] pick;
   logic [15:0] pick_vec;
   logic fire;
   logic in_sfr;
   logic in_ram;
   logic trap_fetch;
   logic trap_active;

   // ***************************************************
   // trap detection and reset stretch
   // ***************************************************
   // special area is the first 64 bytes of the address space
   assign in_sfr = fetch_addr[15:6] == 10'h000;
   assign in_ram = fetch_addr >= ram_base && fetch_addr <= ram_limit;
   assign trap_fetch = fetch_valid && (in_sfr || (ram_trap_select && in_ram));

   pic_trap_pulse #(
      .LEN(TRAP_LEN)
   ) u_trap (
      .sys_clk(sys_clk),
      .reset(reset),
      .fire(trap_fetch && trap_reset_select),
      .active(trap_active)
   );

   // trap reset output is the stretcher flop itself
   assign trap_reset = trap_active;

   // watchdog reset when its select is still at the reset default
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         wdog_reset <= 1'b0;
      end else begin
         wdog_reset <= wdog_event && wdog_reset_select;
      end
   end

   // ***************************************************
   // request latches
   // ***************************************************
   // a written zero clears, a written one leaves the latch alone
   always_comb begin
      wr_clr = 16'h0000;
      if (sfr_req.wr && sfr_req.addr == `PIC_OFS_PEND_LO) begin
         wr_clr[7:0] = ~sfr_req.wdata;
      end
      if (sfr_req.wr && sfr_req.addr == `PIC_OFS_PEND_HI) begin
         wr_clr[15:8] = ~sfr_req.wdata;
      end
   end

   // trap and watchdog raise latches only in interrupt mode
   always_comb begin
      set_vec = src_req;
      set_vec[1:0] = 2'b00;
      set_vec[`PIC_IDX_TRAP] = (trap_fetch || fetch_trap_event) && !trap_reset_select;
      set_vec[`PIC_IDX_WDOG] = wdog_event && !wdog_reset_select;
   end

   assign ack_clr = fire && !soft_irq && !illegal_opcode_irq ? (16'h0001 << pick) : 16'h0000;

   // set wins over both write clear and acceptance clear
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         latch_reg <= `PIC_LATCH_RESET;
      end else begin
         latch_reg <= (latch_reg & ~wr_clr & ~ack_clr) | set_vec;
      end
   end

   // ***************************************************
   // enable register and master enable
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         en_reg <= `PIC_EN_RESET;
      end else begin
         if (sfr_req.wr && sfr_req.addr == `PIC_OFS_EN_LO) begin
            en_reg[7:0] <= sfr_req.wdata;
         end
         if (sfr_req.wr && sfr_req.addr == `PIC_OFS_EN_HI) begin
            en_reg[15:8] <= sfr_req.wdata;
         end
         if (fire) begin
            en_reg[`PIC_MIE_BIT] <= 1'b0;
         end else if (return_op) begin
            en_reg[`PIC_MIE_BIT] <= saved_mie;
         end
      end
   end

   // ***************************************************
   // priority resolution
   // ***************************************************
   always_comb begin
      eligible = 16'h0000;
      // maskables need latch, flag and master enable; source zero also its gate
      eligible[15:4] = latch_reg[15:4] & en_reg[15:4] & {12{en_reg[`PIC_MIE_BIT]}};
      eligible[4] = eligible[4] && ext_irq_zero_gate;
      // non-maskables bypass the enable register entirely
      eligible[3:2] = latch_reg[3:2];
   end

   assign any_nm = soft_irq || illegal_opcode_irq || eligible[2] || eligible[3];
   assign any_mask = |eligible[15:4];

   // non-maskables share one level; lowest index is taken first among them
   always_comb begin
      pick = 4'h0;
      pick_vec = `PIC_VEC_SOFT;
      if (soft_irq || illegal_opcode_irq) begin
         pick = 4'h1;
         pick_vec = `PIC_VEC_SOFT;
      end else if (eligible[2]) begin
         pick = 4'h2;
         pick_vec = `PIC_VEC_TRAP;
      end else if (eligible[3]) begin
         pick = 4'h3;
         pick_vec = `PIC_VEC_WDOG;
      end else begin
         for (int i = NSRC - 1; i >= `PIC_IDX_MASK_LO; i--) begin
            if (eligible[i]) begin
               pick = 4'(i);
               pick_vec = `PIC_VEC_MASK_TOP - 16'(2 * i);
            end
         end
      end
   end

   // sample in the final cycle of an instruction only, never mid-sequence
   assign fire = final_cycle && (state_reg == pic_pkg::PIC_IDLE) && (any_nm || any_mask);

   // ***************************************************
   // acceptance sequencer: push psw+mie, pch, pcl, then vector
   // ***************************************************
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         state_reg <= pic_pkg::PIC_IDLE;
      end else begin
         unique case (state_reg)
            pic_pkg::PIC_IDLE: begin
               if (fire) begin
                  state_reg <= pic_pkg::PIC_PUSH_PSW;
               end
            end
            pic_pkg::PIC_PUSH_PSW: state_reg <= pic_pkg::PIC_PUSH_PCH;
            pic_pkg::PIC_PUSH_PCH: state_reg <= pic_pkg::PIC_PUSH_PCL;
            pic_pkg::PIC_PUSH_PCL: state_reg <= pic_pkg::PIC_VECTOR;
            pic_pkg::PIC_VECTOR: state_reg <= pic_pkg::PIC_IDLE;
         endcase
      end
   end

   // capture the winner and the context at the moment of acceptance
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sel_reg <= 4'h0;
         vec_reg <= `PIC_VEC_RESET;
         sel_nm_reg <= 1'b0;
         pc_reg <= 16'h0000;
         psw_reg <= 8'h00;
         mie_reg <= 1'b0;
      end else if (fire) begin
         sel_reg <= pick;
         vec_reg <= pick_vec;
         sel_nm_reg <= any_nm;
         pc_reg <= cur_pc;
         psw_reg <= cur_psw;
         mie_reg <= en_reg[`PIC_MIE_BIT];
      end
   end

   // stack write port, one byte per cycle, three in all
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         stack_we <= 1'b0;
         stack_wdata <= 8'h00;
      end else begin
         stack_we <= 1'b0;
         stack_wdata <= 8'h00;
         unique case (state_reg)
            pic_pkg::PIC_PUSH_PSW: begin
               stack_we <= 1'b1;
               stack_wdata <= {psw_reg[7:1], mie_reg};
            end
            pic_pkg::PIC_PUSH_PCH: begin
               stack_we <= 1'b1;
               stack_wdata <= pc_reg[15:8];
            end
            pic_pkg::PIC_PUSH_PCL: begin
               stack_we <= 1'b1;
               stack_wdata <= pc_reg[7:0];
            end
            default: begin
               stack_we <= 1'b0;
            end
         endcase
      end
   end

   // vector handed over together with the third push (pcl); nesting is left to software
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         accept <= '0;
         busy <= 1'b0;
      end else begin
         accept.take <= state_reg == pic_pkg::PIC_PUSH_PCL;
         accept.vector <= vec_reg;
         accept.source <= sel_reg;
         busy <= fire || (state_reg != pic_pkg::PIC_IDLE && state_reg != pic_pkg::PIC_VECTOR);
      end
   end

   // ***************************************************
   // register read-back
   // ***************************************************
   // unmapped offsets read zero
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         sfr_rdata <= 8'h00;
      end else if (sfr_req.rd) begin
         unique case (sfr_req.addr)
            `PIC_OFS_EN_LO: sfr_rdata <= en_reg[7:0];
            `PIC_OFS_EN_HI: sfr_rdata <= en_reg[15:8];
            `PIC_OFS_PEND_LO: sfr_rdata <= latch_reg[7:0];
            `PIC_OFS_PEND_HI: sfr_rdata <= latch_reg[15:8];
            default: sfr_rdata <= 8'h00;
         endcase
      end
   end
endmodule
`default_nettype wire

// ===== verilog/pic_map.svh
// register offsets, field positions, reset values and timing counts of the interrupt controller
`ifndef PIC_MAP_SVH
`define PIC_MAP_SVH

// ***************************************************
// register offsets in the special-function area
// ***************************************************
`define PIC_OFS_EN_LO 8'h3A
`define PIC_OFS_EN_HI 8'h3B
`define PIC_OFS_PEND_LO 8'h3C
`define PIC_OFS_PEND_HI 8'h3D

// ***************************************************
// field positions and reset values
// ***************************************************
`define PIC_MIE_BIT 0
`define PIC_IDX_TRAP 2
`define PIC_IDX_WDOG 3
`define PIC_IDX_MASK_LO 4
`define PIC_EN_RESET 16'h0000
`define PIC_LATCH_RESET 16'h0000

// ***************************************************
// vectors
// ***************************************************
`define PIC_VEC_RESET 16'hFFFE
`define PIC_VEC_SOFT 16'hFFFC
`define PIC_VEC_TRAP 16'hFFFA
`define PIC_VEC_WDOG 16'hFFF8
`define PIC_VEC_MASK_TOP 16'hFFFE

// ***************************************************
// timing: trap reset length, in oscillator periods
// ***************************************************
`define PIC_TRAP_RST_OSC_PERIODS 24
`define PIC_TRAP_RST_CYCLES (`PIC_TRAP_RST_OSC_PERIODS)

`endif

// ===== verilog/pic_pkg.sv
// types of the interrupt controller
package pic_pkg;
   // acceptance sequencer states
   typedef enum logic [2:0] {
      PIC_IDLE,
      PIC_PUSH_PSW,
      PIC_PUSH_PCH,
      PIC_PUSH_PCL,
      PIC_VECTOR
   } pic_state_e;

   // special-function bus request from the cpu core
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } pic_sfr_req_s;

   // acceptance answer towards the cpu core
   typedef struct packed {
      logic take;
      logic [15:0] vector;
      logic [3:0] source;
   } pic_accept_s;
endpackage

// ===== verilog/pic_trap_pulse.sv
// stretcher that holds the address-trap reset for a fixed count of cycles
`timescale 1ns/10ps
`default_nettype none
module pic_trap_pulse #(
   parameter int LEN = 24
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic fire,
   output logic active
);
   logic [7:0] cnt_reg;

   // load on fire, count down; never re-arm while running to bound the length
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         cnt_reg <= 8'h00;
      end else if (fire && cnt_reg == 8'h00) begin
         cnt_reg <= 8'(LEN);
      end else if (cnt_reg != 8'h00) begin
         cnt_reg <= cnt_reg - 8'h01;
      end
   end

   // registered so the reset output comes straight from a flip-flop
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         active <= 1'b0;
      end else begin
         active <= (fire && cnt_reg == 8'h00) || cnt_reg > 8'h01;
      end
   end
endmodule
`default_nettype wire

// ===== dv/pic_ctrl_props.sv
// checker of the interrupt controller port behaviour
`timescale 1ns/10ps
`default_nettype none
module pic_ctrl_props #(
   parameter int TRAP_LEN = 24
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire pic_pkg::pic_sfr_req_s sfr_req,
   input wire logic [7:0] sfr_rdata,
   input wire logic wdog_event,
   input wire logic wdog_reset_select,
   input wire logic final_cycle,
   input wire logic [15:0] cur_pc,
   input wire logic [7:0] cur_psw,
   input wire logic stack_we,
   input wire logic [7:0] stack_wdata,
   input wire pic_pkg::pic_accept_s accept,
   input wire logic busy,
   input wire logic trap_reset,
   input wire logic wdog_reset
);
   // ****
   // port relations
   // ****
   int tcnt;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // length of the running trap reset; a counter, since the length is a parameter
   always_ff @(posedge sys_clk) begin
      if (reset || !trap_reset) tcnt <= 0;
      else tcnt <= tcnt + 1;
   end
   walk_order_a:
      assert property ($rose(busy) |-> !stack_we ##1 stack_we[*3] ##1 (!stack_we && !busy))
      else $error("acceptance walk out of order");
   take_last_a:
      assert property (accept.take |-> stack_we && busy)
      else $error("take not with last stack byte");
   vector_map_a:
      assert property (accept.take |-> accept.vector == 16'hFFFE - {11'h000, accept.source, 1'b0})
      else $error("vector does not match source");
   fire_cause_a:
      assert property ($rose(busy) |-> $past(final_cycle))
      else $error("acceptance outside final cycle");
   // context is captured at the fire edge, two samples before the first stack byte shows
   stack_bytes_a:
      assert property ($rose(stack_we) |-> stack_wdata[7:1] == $past(cur_psw[7:1], 2)
         ##1 stack_wdata == $past(cur_pc[15:8], 3) ##1 stack_wdata == $past(cur_pc[7:0], 4))
      else $error("stacked bytes wrong");
   wdog_reset_a:
      assert property ((wdog_event && wdog_reset_select) |-> ##[1:2] wdog_reset)
      else $error("watchdog reset missing");
   trap_len_a:
      assert property ($fell(trap_reset) |-> tcnt == TRAP_LEN)
      else $error("trap reset length wrong");
   rdata_hold_a:
      assert property (!sfr_req.rd |=> $stable(sfr_rdata))
      else $error("read data moved without read");
   cover property (accept.take && accept.source > 4'h3);
   cover property ($rose(trap_reset));
   cover property (wdog_reset);
endmodule
bind pic_ctrl pic_ctrl_props #(.TRAP_LEN(TRAP_LEN)) props (.sys_clk, .reset, .sfr_req,
   .sfr_rdata, .wdog_event, .wdog_reset_select, .final_cycle, .cur_pc, .cur_psw, .stack_we,
   .stack_wdata, .accept, .busy, .trap_reset, .wdog_reset);
`default_nettype wire

// ===== dv/pic_cpu_model.sv
// cpu core model: instruction ends, stack capture and interrupt return
`timescale 1ns/10ps
`default_nettype none
module pic_cpu_model (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic busy,
   input wire logic stack_we,
   input wire logic [7:0] stack_wdata,
   input wire pic_pkg::pic_accept_s accept,
   output logic final_cycle,
   output logic return_op,
   output logic saved_mie,
   output logic [15:0] cur_pc,
   output logic [7:0] cur_psw
);
   // ****
   // instruction flow
   // ****
   logic [1:0] ph;
   logic we_d;
   int rc;
   // four-cycle instructions; the core stalls while acceptance runs
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         ph <= 2'h0;
         final_cycle <= 1'b0;
         cur_pc <= 16'h8000;
         rc <= 0;
         return_op <= 1'b0;
      end else begin
         ph <= ph + 2'h1;
         final_cycle <= (ph == 2'h3) && !busy;
         if (final_cycle) cur_pc <= cur_pc + 16'h0003;
         return_op <= (rc == 1);
         if (accept.take) rc <= 40;
         else if (rc != 0) rc <= rc - 1;
      end
   end
   // first stacked byte holds the master enable that the return restores
   always_ff @(posedge sys_clk) begin
      we_d <= stack_we;
      if (stack_we && !we_d) saved_mie <= stack_wdata[0];
   end
   assign cur_psw = cur_pc[7:0] ^ 8'hA5;
endmodule
`default_nettype wire

// ===== dv/prioritized_interrupt_controller_tb.sv
// self-checking bench of the interrupt controller
`timescale 1ns/10ps
`default_nettype none
module prioritized_interrupt_controller_tb;
   // ****
   // bench
   // ****
   localparam int TL = 4; // short trap reset keeps the run brief
   logic sys_clk, reset, soft_irq, illegal_opcode_irq, wdog_event, fetch_valid;
   logic ram_trap_select, trap_reset_select, wdog_reset_select, ext_irq_zero_gate;
   logic final_cycle, return_op, saved_mie, stack_we, busy, trap_reset, wdog_reset;
   logic [7:0] sfr_rdata, cur_psw, stack_wdata;
   logic [15:0] src_req, fetch_addr, cur_pc;
   pic_pkg::pic_sfr_req_s sfr_req;
   pic_pkg::pic_accept_s accept;
   int n_fail = 0, num_checks = 0, cyc = 0, n_take = 0, n_trap = 0, n_wrst = 0;
   pic_ctrl #(.TRAP_LEN(TL)) dut (.sys_clk, .reset, .sfr_req, .sfr_rdata, .src_req,
      .soft_irq, .illegal_opcode_irq, .fetch_trap_event(1'b0), .wdog_event, .fetch_valid,
      .fetch_addr, .ram_trap_select, .trap_reset_select, .wdog_reset_select,
      .ext_irq_zero_gate, .final_cycle, .return_op, .saved_mie, .cur_pc, .cur_psw,
      .ram_base(16'h0040), .ram_limit(16'h00FF), .stack_we, .stack_wdata, .accept, .busy,
      .trap_reset, .wdog_reset);
   pic_cpu_model cpu (.sys_clk, .reset, .busy, .stack_we, .stack_wdata, .accept,
      .final_cycle, .return_op, .saved_mie, .cur_pc, .cur_psw);
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // event counters and hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (accept.take === 1'b1) n_take++;
      if (trap_reset === 1'b1) n_trap++;
      if (wdog_reset === 1'b1) n_wrst++;
      if (cyc == 20000) begin
         n_fail++;
         end_of_test();
      end
   end
   function automatic logic [15:0] vexp(input int i);
      return 16'hFFFE - 16'(2 * i);
   endfunction
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      num_checks++;
      if (g !== e) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      sfr_req <= '{1'b1, 1'b0, a, d};
      @(posedge sys_clk);
      sfr_req.wr <= 1'b0;
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      @(posedge sys_clk);
      sfr_req <= '{1'b0, 1'b1, a, 8'h00};
      @(posedge sys_clk);
      sfr_req.rd <= 1'b0;
      @(posedge sys_clk);
      #1 chk("register", {8'h00, e}, {8'h00, sfr_rdata});
   endtask
   task automatic req(input logic [15:0] m);
      @(posedge sys_clk);
      src_req <= m;
      @(posedge sys_clk);
      src_req <= 16'h0000;
   endtask
   task automatic wtake(input logic [15:0] ev);
      int n = 0;
      while (accept.take !== 1'b1 && n < 200) begin
         @(posedge sys_clk);
         #1 n++;
      end
      chk("take", 16'h0001, {15'h0000, accept.take});
      chk("vector", ev, accept.vector);
      @(posedge sys_clk);
   endtask
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // main sequence
   initial begin
      int i, j, t;
      {reset, soft_irq, illegal_opcode_irq, wdog_event, fetch_valid} = 5'h10;
      {ram_trap_select, trap_reset_select, wdog_reset_select, ext_irq_zero_gate} = 4'hE;
      sfr_req = '0;
      src_req = 16'h0000;
      fetch_addr = 16'h8000;
      void'($urandom(18));
      repeat (3) @(posedge sys_clk);
      reset <= 1'b0;
      for (i = 0; i < 4; i++) rchk(8'h3A + 8'(i), 8'h00);
      rchk(8'h3E, 8'h00);
      t = $urandom;
      wr(8'h3B, 8'(t));
      rchk(8'h3B, 8'(t));
      wr(8'h3C, 8'hFF);
      rchk(8'h3C, 8'h00);
      $display("test registers done");
      wr(8'h3A, 8'hF0);
      wr(8'h3B, 8'hFF);
      t = n_take;
      req(16'h0020);
      repeat (20) @(posedge sys_clk);
      chk("blocked takes", 16'(t), 16'(n_take));
      rchk(8'h3C, 8'h20);
      wr(8'h3C, 8'hDF);
      rchk(8'h3C, 8'h00);
      @(posedge sys_clk);
      sfr_req <= '{1'b1, 1'b0, 8'h3C, 8'h00};
      src_req <= 16'h0040;
      @(posedge sys_clk);
      sfr_req.wr <= 1'b0;
      src_req <= 16'h0000;
      rchk(8'h3C, 8'h40);
      wr(8'h3C, 8'h0C);
      $display("test masking done");
      ext_irq_zero_gate <= 1'b0;
      wr(8'h3A, 8'hF1);
      req(16'h0010);
      repeat (20) @(posedge sys_clk);
      chk("gated takes", 16'(t), 16'(n_take));
      ext_irq_zero_gate <= 1'b1;
      wtake(vexp(4));
      repeat (50) @(posedge sys_clk);
      for (t = 0; t < 6; t++) begin
         i = 4 + $urandom % 12;
         j = 4 + $urandom % 12;
         req(16'(1 << i) | 16'(1 << j));
         wtake(vexp(i < j ? i : j));
         rchk(8'h3A, 8'hF0);
         if (i != j) wtake(vexp(i > j ? i : j));
         repeat (50) @(posedge sys_clk);
         rchk(8'h3A, 8'hF1);
         rchk(8'h3D, 8'h00);
      end
      $display("test maskable done");
      wr(8'h3A, 8'h00);
      soft_irq <= 1'b1;
      wtake(16'hFFFC);
      soft_irq <= 1'b0;
      illegal_opcode_irq <= 1'b1;
      wtake(16'hFFFC);
      illegal_opcode_irq <= 1'b0;
      wdog_reset_select <= 1'b0;
      @(posedge sys_clk);
      wdog_event <= 1'b1;
      @(posedge sys_clk);
      wdog_event <= 1'b0;
      wtake(16'hFFF8);
      $display("test non-maskable done");
      wdog_reset_select <= 1'b1;
      t = n_wrst;
      @(posedge sys_clk);
      wdog_event <= 1'b1;
      @(posedge sys_clk);
      wdog_event <= 1'b0;
      repeat (10) @(posedge sys_clk);
      chk("watchdog resets", 16'(t + 1), 16'(n_wrst));
      for (i = 0; i < 2; i++) begin
         t = n_trap;
         ram_trap_select <= i[0];
         fetch_addr <= i[0] ? 16'h0080 : 16'h0020;
         fetch_valid <= 1'b1;
         @(posedge sys_clk);
         fetch_valid <= 1'b0;
         repeat (30) @(posedge sys_clk);
         chk("trap reset cycles", 16'(t + TL), 16'(n_trap));
      end
      trap_reset_select <= 1'b0;
      fetch_addr <= 16'h0010;
      fetch_valid <= 1'b1;
      @(posedge sys_clk);
      fetch_valid <= 1'b0;
      wtake(16'hFFFA);
      $display("test trap done");
      repeat (50) @(posedge sys_clk);
      end_of_test();
   end
endmodule
`default_nettype wire
